// >>> rtl/msb_pkg.sv
package msb_pkg;

   // clock and slow tick
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

   // stop method codes
   localparam logic [1:0] STOP_DECEL = 2'h0;
   localparam logic [1:0] STOP_COAST = 2'h1;
   localparam logic [1:0] STOP_DC_BRAKE = 2'h2;
   localparam logic [1:0] STOP_COAST_TIMER = 2'h3;

   // multi-function input terminal codes
   localparam int TERM_COUNT = 5;
   localparam logic [7:0] FN_DC_BRAKE_CMD = 8'h3C;
   localparam logic [7:0] FN_DSTOP_CLOSED = 8'h0F;
   localparam logic [7:0] FN_DSTOP_OPEN = 8'h11;

   // second analog input function codes
   localparam logic [4:0] A2_FN_BRAKE_CURRENT = 5'h06;
   localparam logic [4:0] A2_FN_BRAKE_OVERTORQUE = 5'h07;

   // brake current, percent of rated drive current
   localparam logic [6:0] BRAKE_PCT_MAX = 7'h64;
   localparam logic [6:0] BRAKE_PCT_DEFAULT = 7'h32;
   // analog counts: 1000 counts is 10 V or 20 mA
   localparam logic [9:0] AIN_PER_PCT = 10'h00A;

   // start braking time in 0.01 s steps, 0.00 .. 10.00 s
   localparam logic [9:0] START_TIME_MAX = 10'h3E8;
   localparam logic [9:0] START_TIME_DEFAULT = 10'h000;

   // ramp times: 0.1 s steps (coarse) or 0.01 s steps (fine)
   localparam logic UNIT_FINE = 1'b0;
   localparam logic [15:0] RAMP_TIME_MAX = 16'hEA60;
   localparam logic [15:0] DSTOP_TIME_DEFAULT = 16'h0064;
   localparam logic [3:0] TICKS_PER_COARSE = 4'hA;

   localparam int CNT_W = 20;
   localparam int FREQ_W = 16;

   typedef enum logic [7:0] {
      ST_IDLE = 8'b0000_0001,
      ST_START_BRAKE = 8'b0000_0010,
      ST_RUN = 8'b0000_0100,
      ST_DECEL = 8'b0000_1000,
      ST_COAST = 8'b0001_0000,
      ST_DC_STOP = 8'b0010_0000,
      ST_TERM_BRAKE = 8'b0100_0000,
      ST_FAST_STOP = 8'b1000_0000
   } msb_state_t;

   typedef logic [7:0] msb_func_t;

   typedef struct packed {
      logic [1:0] stop_method_select;
      logic [6:0] dc_brake_current_pct;
      logic [9:0] dc_brake_start_time;
      logic [15:0] decel_time;
      logic [15:0] decel_stop_time;
      logic ramp_time_unit_select;
      logic [4:0] analog_a2_function;
   } msb_settings_t;

   typedef struct packed {
      logic drive_enable;
      logic dc_brake;
      logic decel_stop_ramp;
      logic run_active;
      logic lockout_active;
   } msb_drive_t;

endpackage

// >>> rtl/msb_tick_div.sv
`timescale 1ns/1ps
module msb_tick_div #(
   parameter int CYCLES = 500000
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // slow enable
   output logic tick_o
);
   import msb_pkg::*;

   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } msb_div_state_t;

   msb_div_state_t s;
   msb_div_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.cnt == LAST) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + W'(1);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick_o = s.tick;
endmodule

// >>> rtl/msb_down_counter.sv
`timescale 1ns/1ps
module msb_down_counter #(
   parameter int W = 20
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // control
   input wire logic load_i,
   input wire logic [W-1:0] load_value_i,
   input wire logic tick_i,
   // status
   output logic [W-1:0] count_o,
   output logic zero_o
);
   import msb_pkg::*;

   typedef struct packed {
      logic [W-1:0] count;
   } msb_cnt_state_t;

   msb_cnt_state_t s;
   msb_cnt_state_t next_s;

   // load beats tick so a freshly loaded value is never decremented in its load cycle
   always_comb begin
      next_s = s;
      if (load_i) begin
         next_s.count = load_value_i;
      end else if (tick_i && s.count != '0) begin
         next_s.count = s.count - W'(1);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign count_o = s.count;
   assign zero_o = (s.count == '0);
endmodule

// >>> rtl/msb_sequencer.sv
`timescale 1ns/1ps
module msb_sequencer #(
   parameter int TICK_CYCLES = msb_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // control terminals
   input wire logic run_cmd_i,
   input wire logic jog_cmd_i,
   input wire logic [msb_pkg::TERM_COUNT-1:0] terminal_i,
   input wire msb_pkg::msb_func_t [msb_pkg::TERM_COUNT-1:0]
      input_terminal_function_i,
   // parameter settings
   input wire msb_pkg::msb_settings_t settings_i,
   // analog and motor feedback
   input wire logic [9:0] second_analog_input_i,
   input wire logic overtorque_det1_i,
   input wire logic [msb_pkg::FREQ_W-1:0] output_freq_i,
   input wire logic motor_stopped_i,
   // output stage commands
   output msb_pkg::msb_drive_t drive_o,
   output logic [6:0] brake_current_pct_o,
   output logic [15:0] ramp_time_o,
   output logic ramp_time_unit_o
);
   import msb_pkg::*;

   typedef struct packed {
      msb_state_t state;
      logic [6:0] brake_pct;
      logic [15:0] ramp_time;
      logic ramp_unit;
   } msb_seq_state_t;

   msb_seq_state_t s;
   msb_seq_state_t next_s;

   logic tick;
   logic run_req;
   logic dstop;
   logic term_brake;
   logic lock_load;
   logic [CNT_W-1:0] lock_value;
   logic [CNT_W-1:0] lock_count;
   logic lock_zero;
   logic start_load;
   logic [CNT_W-1:0] start_value;
   logic start_zero;
   logic [9:0] start_time;
   logic [6:0] pct_fixed;
   logic [9:0] pct_analog;
   logic [31:0] freq_product;
   logic [15:0] lock_units;
   logic [15:0] stop_time;
   logic brake_state;

   msb_tick_div #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .tick_o(tick)
   );

   msb_down_counter #(
      .W(CNT_W)
   ) u_lockout (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .load_i(lock_load),
      .load_value_i(lock_value),
      .tick_i(tick),
      .count_o(lock_count),
      .zero_o(lock_zero)
   );

   msb_down_counter #(
      .W(CNT_W)
   ) u_start_brake (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .load_i(start_load),
      .load_value_i(start_value),
      .tick_i(tick),
      .count_o(),
      .zero_o(start_zero)
   );

   // terminal decode; jog counts as a run request
   always_comb begin
      run_req = run_cmd_i | jog_cmd_i;
      dstop = 1'b0;
      term_brake = 1'b0;
      for (int i = 0; i < TERM_COUNT; i++) begin
         if (input_terminal_function_i[i] == FN_DSTOP_CLOSED &&
             terminal_i[i]) begin
            dstop = 1'b1;
         end
         if (input_terminal_function_i[i] == FN_DSTOP_OPEN &&
             !terminal_i[i]) begin
            dstop = 1'b1;
         end
         if (input_terminal_function_i[i] == FN_DC_BRAKE_CMD &&
             terminal_i[i]) begin
            term_brake = 1'b1;
         end
      end
   end

   // settings clamped to their legal ranges
   always_comb begin
      start_time = settings_i.dc_brake_start_time;
      if (start_time > START_TIME_MAX) begin
         start_time = START_TIME_MAX;
      end
      pct_fixed = settings_i.dc_brake_current_pct;
      if (pct_fixed > BRAKE_PCT_MAX) begin
         pct_fixed = BRAKE_PCT_MAX;
      end
      // full scale saturates at 100 percent
      pct_analog = second_analog_input_i / AIN_PER_PCT;
      if (pct_analog > 10'(BRAKE_PCT_MAX)) begin
         pct_analog = 10'(BRAKE_PCT_MAX);
      end
      stop_time = settings_i.decel_stop_time;
      if (stop_time > RAMP_TIME_MAX) begin
         stop_time = RAMP_TIME_MAX;
      end
   end

   // lockout: decel time scaled by output frequency over full scale
   always_comb begin
      freq_product = 32'(settings_i.decel_time) * 32'(output_freq_i);
      lock_units = freq_product[31:16];
      if (settings_i.ramp_time_unit_select == UNIT_FINE) begin
         lock_value = CNT_W'(lock_units);
      end else begin
         lock_value = CNT_W'(lock_units) * CNT_W'(TICKS_PER_COARSE);
      end
      start_value = CNT_W'(start_time);
   end

   always_comb begin
      next_s = s;
      lock_load = 1'b0;
      start_load = 1'b0;
      case (s.state)
         ST_IDLE: begin
            if (run_req && !dstop) begin
               start_load = 1'b1;
               next_s.state = (start_time != '0) ?
                  ST_START_BRAKE : ST_RUN;
            end else if (term_brake) begin
               next_s.state = ST_TERM_BRAKE;
            end
         end
         ST_TERM_BRAKE: begin
            if (run_req && !dstop) begin
               start_load = 1'b1;
               next_s.state = (start_time != '0) ?
                  ST_START_BRAKE : ST_RUN;
            end else if (!term_brake) begin
               next_s.state = ST_IDLE;
            end
         end
         ST_START_BRAKE: begin
            if (!run_req) begin
               next_s.state = ST_IDLE;
            end else if (start_zero) begin
               next_s.state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (dstop) begin
               next_s.state = ST_FAST_STOP;
            end else if (!run_req) begin
               case (settings_i.stop_method_select)
                  STOP_DECEL: next_s.state = ST_DECEL;
                  STOP_COAST: next_s.state = ST_COAST;
                  STOP_DC_BRAKE: next_s.state = ST_DC_STOP;
                  STOP_COAST_TIMER: begin
                     lock_load = 1'b1;
                     next_s.state = ST_COAST;
                  end
                  default: next_s.state = ST_DECEL;
               endcase
            end
         end
         ST_DECEL: begin
            if (dstop) begin
               next_s.state = ST_FAST_STOP;
            end else if (run_req) begin
               next_s.state = ST_RUN;
            end else if (motor_stopped_i) begin
               next_s.state = ST_IDLE;
            end
         end
         ST_COAST: begin
            // run requests stay unseen until the lockout runs out
            if (lock_zero) begin
               next_s.state = ST_IDLE;
            end
         end
         ST_DC_STOP: begin
            if (motor_stopped_i) begin
               next_s.state = ST_IDLE;
            end
         end
         ST_FAST_STOP: begin
            // held here until stopped and both commands released
            if (motor_stopped_i && !run_req && !dstop) begin
               next_s.state = ST_IDLE;
            end
         end
         default: next_s.state = ST_IDLE;
      endcase
      if (settings_i.analog_a2_function == A2_FN_BRAKE_CURRENT) begin
         next_s.brake_pct = pct_analog[6:0];
      end else begin
         next_s.brake_pct = pct_fixed;
      end
      if (next_s.state == ST_FAST_STOP) begin
         next_s.ramp_time = stop_time;
      end else if (settings_i.decel_time > RAMP_TIME_MAX) begin
         next_s.ramp_time = RAMP_TIME_MAX;
      end else begin
         next_s.ramp_time = settings_i.decel_time;
      end
      next_s.ramp_unit = settings_i.ramp_time_unit_select;
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         s.state <= ST_IDLE;
         s.brake_pct <= BRAKE_PCT_DEFAULT;
         s.ramp_time <= DSTOP_TIME_DEFAULT;
         s.ramp_unit <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign brake_state = (s.state == ST_START_BRAKE) ||
      (s.state == ST_TERM_BRAKE) || (s.state == ST_DC_STOP);

   always_comb begin
      drive_o.drive_enable = (s.state == ST_RUN) ||
         (s.state == ST_DECEL) ||
         (s.state == ST_FAST_STOP && !motor_stopped_i);
      drive_o.dc_brake = brake_state &&
         (settings_i.analog_a2_function != A2_FN_BRAKE_OVERTORQUE ||
          overtorque_det1_i);
      drive_o.decel_stop_ramp = (s.state == ST_FAST_STOP);
      drive_o.run_active = (s.state == ST_RUN);
      drive_o.lockout_active = (s.state == ST_COAST);
   end

   assign brake_current_pct_o = s.brake_pct;
   assign ramp_time_o = s.ramp_time;
   assign ramp_time_unit_o = s.ramp_unit;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_timed_stop;
      s.state == ST_RUN && !run_req && !dstop &&
         settings_i.stop_method_select == STOP_COAST_TIMER;
   endsequence

   sequence s_clean_start;
      s.state == ST_IDLE && run_req && !dstop;
   endsequence

   AST_TIMED_COAST_CUTS: assert property (
      s_timed_stop |=> s.state == ST_COAST && !drive_o.drive_enable)
      else $error("timed stop did not cut drive output");
   AST_LOCKOUT_HOLDS: assert property (
      s.state == ST_COAST && !lock_zero |=> s.state == ST_COAST)
      else $error("run accepted during lockout");
   AST_LOCKOUT_VALUE: assert property (
      s_timed_stop |=> lock_count == $past(lock_value))
      else $error("lockout not loaded from frequency and decel time");
   // run may drop during start braking, so only a held run is judged
   AST_START_BRAKES: assert property (
      s_clean_start ##0 start_time != '0 ##1 run_req |->
         s.state == ST_START_BRAKE ##1 s.state == ST_START_BRAKE)
      else $error("start braking skipped");
   AST_ZERO_NO_BRAKE: assert property (
      s_clean_start ##0 start_time == '0 |=> s.state == ST_RUN)
      else $error("start braking applied with zero time");
   AST_TERM_BRAKE: assert property (
      s.state == ST_IDLE && term_brake && !run_req |=>
         s.state == ST_TERM_BRAKE)
      else $error("terminal brake command not honoured");
   AST_TERM_RESUME: assert property (
      s.state == ST_TERM_BRAKE && run_req && !dstop |=>
         s.state != ST_TERM_BRAKE)
      else $error("terminal braking not ended by run");
   AST_ANALOG_PCT: assert property (
      settings_i.analog_a2_function == A2_FN_BRAKE_CURRENT &&
         second_analog_input_i == 10'h3E8 |=>
         brake_current_pct_o == BRAKE_PCT_MAX)
      else $error("analog full scale not 100 percent");
   AST_FAST_STOP_HOLD: assert property (
      s.state == ST_FAST_STOP && !motor_stopped_i |=>
         s.state == ST_FAST_STOP && ramp_time_o == $past(stop_time))
      else $error("restart before decel stop completed");
endmodule

// >>> sim/msb_motor_model.sv
`timescale 1ns/1ps
module msb_motor_model (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // output stage commands
   input wire msb_pkg::msb_drive_t drive_i,
   // motor state
   output logic motor_stopped_o
);
   import msb_pkg::*;
   logic [5:0] speed;
   // coarse speed: spins up when driven, loses speed fastest under dc brake
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         speed <= 6'h00;
      end else if (drive_i.run_active && drive_i.drive_enable) begin
         speed <= (speed == 6'h3F) ? speed : speed + 6'h01;
      end else if (drive_i.dc_brake) begin
         speed <= (speed < 6'h04) ? 6'h00 : speed - 6'h04;
      end else if (drive_i.drive_enable) begin
         speed <= (speed < 6'h02) ? 6'h00 : speed - 6'h02;
      end else if (speed != 6'h00) begin
         speed <= speed - 6'h01;
      end
   end
   // stopped only at true zero speed, never early
   assign motor_stopped_o = (speed == 6'h00);
endmodule

// >>> sim/msb_sequencer_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
`define WAITC(c) begin k = 0; while (!(c) && k < 300) begin \
   @(negedge clock_i); k = k + 1; end \
   if (k >= 300) check_val(32'h0, 32'h1); end
module msb_sequencer_bench;
   import msb_pkg::*;
   localparam int TCK = 4;
   typedef struct {
      logic [4:0] fn;
      logic [6:0] pct;
      logic [9:0] ain;
      logic unit;
      logic [15:0] dt;
      logic [6:0] exp_pct;
   } msb_row_t;
   msb_row_t rows [7] = '{
      '{5'h00, 7'h32, 10'h3E8, 1'b0, 16'h0014, 7'h32},
      '{5'h00, 7'h64, 10'h000, 1'b1, 16'h0064, 7'h64},
      '{5'h00, 7'h78, 10'h000, 1'b0, 16'hEA60, 7'h64},
      '{5'h06, 7'h32, 10'h3E8, 1'b1, 16'h0001, 7'h64},
      '{5'h06, 7'h00, 10'h1F4, 1'b0, 16'h0014, 7'h32},
      '{5'h06, 7'h32, 10'h3FF, 1'b0, 16'h0014, 7'h64},
      '{5'h06, 7'h32, 10'h000, 1'b0, 16'h0014, 7'h00}};
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic run_cmd_i = 1'b0;
   logic jog = 1'b0;
   logic otd = 1'b0;
   logic [TERM_COUNT-1:0] terminal_i = '0;
   msb_func_t [TERM_COUNT-1:0] term_fn = '0;
   msb_settings_t st = '{2'h1, 7'h32, 10'h000, 16'h0014, 16'h0064, 1'b0,
      5'h00};
   logic [9:0] ain = 10'h000;
   logic [FREQ_W-1:0] freq = 16'h8000;
   logic stopped;
   msb_drive_t drive;
   logic [6:0] bpct;
   logic [15:0] ramp;
   logic unit;
   int n_fail = 0;
   int n_checks = 0;
   int k;
   int exp_cyc;
   always #10 clock_i = ~clock_i;

   msb_sequencer #(.TICK_CYCLES(TCK)) dut_u (.clock_i(clock_i),
      .reset_n_i(reset_n_i), .run_cmd_i(run_cmd_i), .jog_cmd_i(jog),
      .terminal_i(terminal_i), .input_terminal_function_i(term_fn),
      .settings_i(st), .second_analog_input_i(ain),
      .overtorque_det1_i(otd), .output_freq_i(freq),
      .motor_stopped_i(stopped), .drive_o(drive),
      .brake_current_pct_o(bpct), .ramp_time_o(ramp),
      .ramp_time_unit_o(unit));
   msb_motor_model motor_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .drive_i(drive), .motor_stopped_o(stopped));

   task automatic check_val(input logic [31:0] got, input logic [31:0] ex);
      n_checks++;
      if (got !== ex) begin
         n_fail++;
         $display("MISMATCH t=%0t got=0x%0h exp=0x%0h", $time, got, ex);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   task automatic run_up;
      run_cmd_i = 1'b1;
      `WAITC(drive.run_active)
      step(70);
   endtask
   task automatic conclude;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // bounded by the expected length of all scenarios with ample margin
   initial begin
      repeat (20000) @(posedge clock_i);
      check_val(32'h0, 32'h1);
      conclude();
   end

   initial begin
      step(11);
      `CHK(drive, 5'h00);
      `CHK(bpct, 7'h32);
      `CHK(ramp, 16'h0064);
      `CHK(unit, 1'b1);
      step(1);
      reset_n_i = 1'b1;
      foreach (rows[i]) begin
         st.analog_a2_function = rows[i].fn;
         st.dc_brake_current_pct = rows[i].pct;
         st.ramp_time_unit_select = rows[i].unit;
         st.decel_time = rows[i].dt;
         ain = rows[i].ain;
         step(3);
         `CHK(bpct, rows[i].exp_pct);
         `CHK(ramp, rows[i].dt);
         `CHK(unit, rows[i].unit);
      end
      st = '{2'h1, 7'h32, 10'h000, 16'h0014, 16'hFFFF, 1'b0, 5'h00};
      step(2);
      // stop methods 0..2
      for (int m = 0; m < 3; m++) begin
         st.stop_method_select = 2'(m);
         run_up();
         run_cmd_i = 1'b0;
         step(2);
         `CHK(drive.run_active, 1'b0);
         `CHK(drive.drive_enable, m == 0);
         `CHK(drive.dc_brake, m == 2);
         `WAITC(drive == 5'h00)
         `CHK(stopped, m != 1);
         `WAITC(stopped)
      end
      // timed coast, lockout scales with frequency at stop
      st.stop_method_select = STOP_COAST_TIMER;
      for (int f = 0; f < 2; f++) begin
         freq = f ? 16'h4000 : 16'h8000;
         run_up();
         run_cmd_i = 1'b0;
         step(2);
         `CHK(drive.drive_enable, 1'b0);
         `CHK(drive.lockout_active, 1'b1);
         run_cmd_i = 1'b1;
         `WAITC(!drive.lockout_active)
         exp_cyc = ((20 * int'(freq)) >> 16) * TCK;
         `CHK(k + 2 >= exp_cyc - TCK && k + 2 <= exp_cyc + 2 * TCK, 1);
         `WAITC(drive.run_active)
         `CHK(k <= 3, 1);
         st.stop_method_select = STOP_COAST;
         run_cmd_i = 1'b0;
         `WAITC(stopped)
         st.stop_method_select = STOP_COAST_TIMER;
      end
      st.stop_method_select = STOP_COAST;
      // start braking: three ticks, then zero disables it
      st.dc_brake_start_time = 10'h003;
      run_cmd_i = 1'b1;
      step(2);
      `CHK(drive.dc_brake, 1'b1);
      `CHK(drive.run_active, 1'b0);
      `WAITC(drive.run_active)
      // first decrement may land up to one tick early after the load
      `CHK(k + 2 >= 2 * TCK + 3 && k + 2 <= 3 * TCK + 2, 1);
      `CHK(drive.dc_brake, 1'b0);
      run_cmd_i = 1'b0;
      step(3);
      st.dc_brake_start_time = START_TIME_DEFAULT;
      run_cmd_i = 1'b1;
      step(2);
      `CHK(drive.run_active, 1'b1);
      // terminal brake command, overtorque gate, jog release
      term_fn[0] = FN_DC_BRAKE_CMD;
      terminal_i[0] = 1'b1;
      step(3);
      `CHK(drive.dc_brake, 1'b0);
      run_cmd_i = 1'b0;
      step(3);
      `CHK(drive.dc_brake, 1'b1);
      st.analog_a2_function = A2_FN_BRAKE_OVERTORQUE;
      step(3);
      `CHK(drive.dc_brake, 1'b0);
      otd = 1'b1;
      step(3);
      `CHK(drive.dc_brake, 1'b1);
      jog = 1'b1;
      step(3);
      `CHK(drive.run_active, 1'b1);
      `CHK(drive.dc_brake, 1'b0);
      jog = 1'b0;
      terminal_i[0] = 1'b0;
      otd = 1'b0;
      st.analog_a2_function = 5'h00;
      `WAITC(stopped)
      // decel stop, closed-active then open-active
      for (int c = 0; c < 2; c++) begin
         term_fn[1] = c ? FN_DSTOP_OPEN : FN_DSTOP_CLOSED;
         terminal_i[1] = c[0];
         st.ramp_time_unit_select = 1'b1;
         run_up();
         terminal_i[1] = ~terminal_i[1];
         step(3);
         `CHK(drive.decel_stop_ramp, 1'b1);
         `CHK(ramp, RAMP_TIME_MAX);
         `CHK(drive.run_active, 1'b0);
         `WAITC(stopped)
         step(5);
         `CHK(drive.run_active, 1'b0);
         run_cmd_i = 1'b0;
         terminal_i[1] = ~terminal_i[1];
         step(3);
         run_cmd_i = 1'b1;
         step(3);
         `CHK(drive.run_active, 1'b1);
         run_cmd_i = 1'b0;
         `WAITC(stopped)
      end
      // reset in mid-run: outputs back to reset values, then a clean start
      run_up();
      reset_n_i = 1'b0;
      step(2);
      `CHK(drive, 5'h00);
      `CHK(bpct, BRAKE_PCT_DEFAULT);
      `CHK(ramp, DSTOP_TIME_DEFAULT);
      `CHK(unit, 1'b1);
      reset_n_i = 1'b1;
      step(2);
      `CHK(drive.run_active, 1'b1);
      run_cmd_i = 1'b0;
      `WAITC(stopped)
      conclude();
   end
endmodule
